// [src/tdmpl_pkg.sv]
// Shared constants, types and decodes for the timing-mode control block.
// Assumes a 125 MHz system clock; every time below is turned into cycles of it.

package tdmpl_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, 16-bit registers in low lanes)
  // ----------------------------------------------------------------
  localparam logic [11:0] MAIN_CONTROL_OFS = 12'h000;
  localparam logic [11:0] PLL_MODE_OFS     = 12'h004;
  localparam logic [11:0] PLL_STATUS_OFS   = 12'h008;
  localparam logic [11:0] PLL_ADJUST_OFS   = 12'h00c;

  // Field positions
  localparam int CTRL_BYPASS_BIT = 14;
  localparam int MODE_SEL_BIT    = 0;
  localparam int MODE_FREQ_LSB   = 1;
  localparam int MODE_REF_POLARITY_INVERT_BIT   = 3;
  localparam int MODE_REFSEL_BIT = 4;
  localparam int STAT_FAIL_BIT   = 0;
  localparam int STAT_MODE_LSB   = 1;
  localparam int STAT_LOCK_BIT   = 3;
  localparam int ADJ_POS_LSB     = 0;
  localparam int ADJ_SKEW_LSB    = 8;
  localparam int POS_W           = 7;
  localparam int SKEW_W          = 3;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Pin synchroniser reset levels {osc, ext ref, frame pulse (active low), bus clock}
  localparam logic [3:0]  PIN_IDLE  = 4'h2;

  // Reference frequency codes
  localparam logic [1:0] FREQ_8K   = 2'h0;
  localparam logic [1:0] FREQ_1544 = 2'h1;
  localparam logic [1:0] FREQ_2048 = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int FRAME_NS       = 125000;
  localparam int FRAME_CYC_DEF  = FRAME_NS * 1000 / CLK_PERIOD_PS;
  localparam int REF_1544_PS    = 647668;
  localparam int REF_2048_PS    = 488281;
  localparam logic [15:0] NOM_1544_CYC = 16'(REF_1544_PS / CLK_PERIOD_PS);
  localparam logic [15:0] NOM_2048_CYC = 16'(REF_2048_PS / CLK_PERIOD_PS);
  localparam int MIN_PULSE_NS   = 90;
  localparam int MIN_PULSE_CYC  = (MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TOL_8K_SHIFT   = 5;
  localparam int TOL_LINE_SHIFT = 2;
  localparam int SKEW_TAPS      = 8;
  localparam int SKEW_TAP_PS    = 1900;
  localparam int SKEW_TAP_RAW   = (SKEW_TAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SKEW_TAP_CYC   = (SKEW_TAP_RAW < 1) ? 1 : SKEW_TAP_RAW;
  localparam int PHASE_STEP_PS  = 15200;
  localparam int PHASE_STEP_RAW = PHASE_STEP_PS / CLK_PERIOD_PS;
  localparam int PHASE_STEP_CYC = (PHASE_STEP_RAW < 1) ? 1 : PHASE_STEP_RAW;
  localparam int SW_CLK_BIT     = 1;

  typedef enum logic [1:0] {MODE_MASTER, MODE_FREERUN, MODE_BYPASS} tdmpl_mode_e;

  // Bypass overrides the mode bit
  function automatic tdmpl_mode_e decodeMode(input logic bypass, input logic modeBit);
    if (bypass) begin
      return MODE_BYPASS;
    end else if (modeBit) begin
      return MODE_FREERUN;
    end
    return MODE_MASTER;
  endfunction

  // Nominal reference period in cycles for a frequency code
  function automatic logic [15:0] nomCycles(input logic [1:0] f, input int frameCyc);
    if (f == FREQ_8K) begin
      return 16'(frameCyc);
    end else if (f == FREQ_1544) begin
      return NOM_1544_CYC;
    end
    return NOM_2048_CYC;
  endfunction

endpackage

// [src/tdmpl_skew_line.sv]
// Tapped delay line that skews the selected reference.
// Assumes sys_clk domain input; one tap is at least one clock cycle.

`timescale 1ns/100ps

module tdmpl_skew_line import tdmpl_pkg::*; #(
  parameter int TAPS    = SKEW_TAPS,
  parameter int TAP_CYC = SKEW_TAP_CYC
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Reference in, tap choice, reference out
  input  wire logic              refIn,
  input  wire logic [SKEW_W-1:0] tapSel,
  output logic                   refOut
);

  localparam int LEN = TAPS * TAP_CYC;

  if (TAPS != (1 << SKEW_W) || TAP_CYC < 1) begin : gBadCfg
    $error("skew line: tap count must match the select width");
  end

  logic [LEN-1:0] line_ff;
  logic [LEN-1:0] nxt_line;
  logic           nxt_refOut;

  // Shift the reference along and pick one tap
  always_comb begin
    nxt_line   = {line_ff[LEN-2:0], refIn};
    nxt_refOut = line_ff[int'(tapSel) * TAP_CYC];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_ff <= '0;
      refOut  <= 1'b0;
    end else begin
      line_ff <= nxt_line;
      refOut  <= nxt_refOut;
    end
  end

  chk_skew_zero_tap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tapSel == 3'h0 && $past(tapSel) == 3'h0) |-> refOut == $past(refIn, 2))
    else $error("skew tap 0 delay wrong");

endmodule

// [src/tdmpl_ref_monitor.sv]
// Validity monitor for the selected timing reference.
// Assumes refIn is already in the sys_clk domain.

`timescale 1ns/100ps

module tdmpl_ref_monitor import tdmpl_pkg::*; #(
  parameter int FRAME_CYC = FRAME_CYC_DEF
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Reference and its programmed frequency
  input  wire logic       refIn,
  input  wire logic [1:0] freqSel,
  // Validity
  output logic            refFail
);

  localparam logic [15:0] MIN_M1 = 16'(MIN_PULSE_CYC - 1);

  logic        refPrev_ff, seenRise_ff;
  logic [15:0] pulseCnt_ff, perCnt_ff;
  logic        nxt_refPrev, nxt_seenRise, nxt_fail;
  logic [15:0] nxt_pulseCnt, nxt_perCnt;
  logic [15:0] nom, tol, lo, hi, perLen;
  logic        rise, edgeAny, shortPulse, badPer, good;

  // Edge timing checks: pulse width, period window, missing edges
  always_comb begin
    rise    = refIn & ~refPrev_ff;
    edgeAny = refIn ^ refPrev_ff;
    nom     = nomCycles(freqSel, FRAME_CYC);
    tol     = (freqSel == FREQ_8K) ? (nom >> TOL_8K_SHIFT) : (nom >> TOL_LINE_SHIFT);
    lo      = nom - tol;
    hi      = nom + tol;
    perLen  = perCnt_ff + 16'h0001;
    shortPulse = edgeAny && (pulseCnt_ff < MIN_M1);
    badPer  = (rise && seenRise_ff && (perLen < lo || perLen > hi)) || (perCnt_ff >= hi);
    good    = rise && seenRise_ff && !badPer && !shortPulse;
    nxt_refPrev  = refIn;
    nxt_seenRise = seenRise_ff | rise;
    nxt_pulseCnt = edgeAny ? 16'h0000 : (&pulseCnt_ff ? pulseCnt_ff : pulseCnt_ff + 16'h0001);
    nxt_perCnt   = rise ? 16'h0000 : (&perCnt_ff ? perCnt_ff : perLen);
    // A failure in the same cycle as a good period wins
    if (shortPulse || badPer) begin
      nxt_fail = 1'b1;
    end else if (good) begin
      nxt_fail = 1'b0;
    end else begin
      nxt_fail = refFail;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refPrev_ff  <= 1'b0;
      seenRise_ff <= 1'b0;
      pulseCnt_ff <= 16'hffff; // Level before the first edge has unknown length
      perCnt_ff   <= 16'h0000;
      refFail     <= 1'b0;
    end else begin
      refPrev_ff  <= nxt_refPrev;
      seenRise_ff <= nxt_seenRise;
      pulseCnt_ff <= nxt_pulseCnt;
      perCnt_ff   <= nxt_perCnt;
      refFail     <= nxt_fail;
    end
  end

  chk_fail_short_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    shortPulse |=> refFail)
    else $error("short reference pulse not flagged");

  chk_fail_good_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (good && !badPer) |=> !refFail)
    else $error("good reference period did not clear failure");

endmodule

// [src/tdmpl_mode_ctrl.sv]
// Timing-mode control of the switch synthesizer: APB registers, mode
// decode, reference selection, a digital frame loop and clock steering.
// Assumes all timing pins are asynchronous to sys_clk (125 MHz).
//
// Overview of operation
// - Bypass bit set gives bypass; else mode bit picks master or free-run.
// - Reset clears every register, so the block starts in master mode.
// - Master mode slips the switch timing toward the selected reference.
// - Free-run ignores the reference; timing comes from the local clock alone.
// - Bypass skips the loop; switch timing follows the bus input clock.
// - Master and free-run feed the oscillator to the loop master clock.
// - A two-bit field sets the nominal reference frequency.
// - The loop acts on rising reference edges; a bit inverts the external one.
// - The selected reference is checked continuously for validity.
// - Phase offset gives coarse lead or lag; skew taps give fine delay.
// - Frame pulse is sampled on the bus input clock into an 8 kHz reference.
// - A select bit picks derived or external reference for the skew stage.
// - Serial inputs are always sampled on the bus input clock edge.
// - Switch timing times the switch and every serial bus output.
// - Entry to free-run is accepted at any moment.
// - In bypass, outputs follow the bus input clock without loop jitter.
// - Eight-tap delay line skews the reference; three bits choose the tap.
// - Seven-bit two's complement offset is added to the phase error.
// - Failure flag reads high when the reference is invalid, low when valid.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.

`timescale 1ns/100ps

module tdmpl_mode_ctrl import tdmpl_pkg::*; #(
  parameter int FRAME_CYC = FRAME_CYC_DEF
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Timing pins from outside
  input  wire logic        busInputClock,
  input  wire logic        busInputFramePulse_n,
  input  wire logic        extReference,
  input  wire logic        oscillatorClock,
  // Timing outputs
  output logic             switchTimingClock,
  output logic             switchTimingTick,
  output logic             busOutputFramePulse_n,
  output logic             inputSampleStrobe,
  output logic             loopMasterClock,
  output logic             multiplierFromBus,
  output logic             loopTracking
);

  if (FRAME_CYC < 64 || FRAME_CYC > 65535) begin : gBadFrame
    $error("mode ctrl: frame length out of counter range");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pinRaw, pinA_ff, pinB_ff;
  logic       busClkS, busFpS_n, extRefS, oscS;

  assign pinRaw = {oscillatorClock, extReference, busInputFramePulse_n, busInputClock};

  // Two flops per pin; reset to idle levels so no false frame pulse follows reset
  for (genvar i = 0; i < 4; i++) begin : gSync
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        pinA_ff[i] <= PIN_IDLE[i];
        pinB_ff[i] <= PIN_IDLE[i];
      end else begin
        pinA_ff[i] <= pinRaw[i];
        pinB_ff[i] <= pinA_ff[i];
      end
    end
  end

  assign {oscS, extRefS, busFpS_n, busClkS} = pinB_ff;

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {SEL_CTRL, SEL_MODE, SEL_STAT, SEL_ADJ, SEL_NONE} tdmpl_sel_e;

  // Address decode shared by the write and read paths
  function automatic tdmpl_sel_e decodeAddr(input logic [11:0] a);
    if (a == MAIN_CONTROL_OFS) begin
      return SEL_CTRL;
    end else if (a == PLL_MODE_OFS) begin
      return SEL_MODE;
    end else if (a == PLL_STATUS_OFS) begin
      return SEL_STAT;
    end else if (a == PLL_ADJUST_OFS) begin
      return SEL_ADJ;
    end
    return SEL_NONE;
  endfunction

  logic [15:0] ctrlReg_ff, modeReg_ff, adjReg_ff;
  logic [15:0] nxt_ctrlReg, nxt_modeReg, nxt_adjReg;
  logic [31:0] nxt_prdata;
  logic [15:0] statusWord;
  tdmpl_sel_e  regSel;
  logic        setupPh, accessPh;
  logic        refFail, locked_ff;
  tdmpl_mode_e curMode;

  assign regSel   = decodeAddr(paddr);
  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  // Zero-wait slave: read data was captured in the setup cycle
  assign pready   = accessPh;
  assign pslverr  = accessPh & (regSel == SEL_NONE);

  // Status word shows live block state
  always_comb begin
    statusWord = 16'h0000;
    statusWord[STAT_FAIL_BIT] = refFail;
    statusWord[STAT_MODE_LSB +: 2] = curMode;
    statusWord[STAT_LOCK_BIT] = locked_ff;
  end

  // Writes land at the access edge; reads are sampled in setup
  always_comb begin
    nxt_ctrlReg = ctrlReg_ff;
    nxt_modeReg = modeReg_ff;
    nxt_adjReg  = adjReg_ff;
    nxt_prdata  = prdata;
    if (accessPh && pwrite) begin
      if (regSel == SEL_CTRL) begin
        nxt_ctrlReg = pwdata[15:0];
      end else if (regSel == SEL_MODE) begin
        nxt_modeReg = pwdata[15:0];
      end else if (regSel == SEL_ADJ) begin
        nxt_adjReg = pwdata[15:0];
      end
    end
    if (setupPh && !pwrite) begin
      nxt_prdata = 32'h0000_0000;
      if (regSel == SEL_CTRL) begin
        nxt_prdata[15:0] = ctrlReg_ff;
      end else if (regSel == SEL_MODE) begin
        nxt_prdata[15:0] = modeReg_ff;
      end else if (regSel == SEL_STAT) begin
        nxt_prdata[15:0] = statusWord;
      end else if (regSel == SEL_ADJ) begin
        nxt_prdata[15:0] = adjReg_ff;
      end
    end
  end

  // All registers clear on reset, which selects master mode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlReg_ff <= REG_RESET;
      modeReg_ff <= REG_RESET;
      adjReg_ff  <= REG_RESET;
      prdata     <= 32'h0000_0000;
    end else begin
      ctrlReg_ff <= nxt_ctrlReg;
      modeReg_ff <= nxt_modeReg;
      adjReg_ff  <= nxt_adjReg;
      prdata     <= nxt_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and reference path
  // ----------------------------------------------------------------
  logic              bypassOn, pinvOn, useDerived;
  logic [1:0]        freqSel;
  logic [SKEW_W-1:0] skewSel;
  logic signed [POS_W-1:0] posWord;
  logic              refPolar, selRef, skewRef;

  // Straight from register contents, no handshake, so free-run entry is immediate
  assign curMode    = decodeMode(ctrlReg_ff[CTRL_BYPASS_BIT], modeReg_ff[MODE_SEL_BIT]);
  assign bypassOn   = (curMode == MODE_BYPASS);
  assign freqSel    = modeReg_ff[MODE_FREQ_LSB +: 2];
  assign pinvOn     = modeReg_ff[MODE_REF_POLARITY_INVERT_BIT];
  assign useDerived = modeReg_ff[MODE_REFSEL_BIT];
  assign skewSel    = adjReg_ff[ADJ_SKEW_LSB +: SKEW_W];
  assign posWord    = signed'(adjReg_ff[ADJ_POS_LSB +: POS_W]);

  logic derived8k_ff, busClkPrev_ff, nxt_derived8k;
  logic busClkRise;

  assign busClkRise = busClkS & ~busClkPrev_ff;

  // Frame pulse caught on each bus clock rise gives the 8 kHz reference
  always_comb begin
    nxt_derived8k = busClkRise ? ~busFpS_n : derived8k_ff;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      derived8k_ff  <= 1'b0;
      busClkPrev_ff <= 1'b0;
    end else begin
      derived8k_ff  <= nxt_derived8k;
      busClkPrev_ff <= busClkS;
    end
  end

  // Only the external input is inverted; the derived one has fixed sense
  assign refPolar = extRefS ^ pinvOn;
  // Derived reference relies on software zeroing the frequency field
  assign selRef   = useDerived ? derived8k_ff : refPolar;

  tdmpl_skew_line uSkew (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .refIn   (selRef),
    .tapSel  (skewSel),
    .refOut  (skewRef)
  );

  tdmpl_ref_monitor #(.FRAME_CYC(FRAME_CYC)) uMon (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .refIn   (selRef),
    .freqSel (freqSel),
    .refFail (refFail)
  );

  // ----------------------------------------------------------------
  // Digital frame loop
  // ----------------------------------------------------------------
  logic [15:0] fbCnt_ff, frameCnt_ff, nxt_fbCnt, nxt_frameCnt, fbPer;
  logic [16:0] fbSum, frSum;
  logic        refPrev_ff, refRise, nxt_locked;
  logic [1:0]  step;
  logic signed [17:0] fbSigned, phaseErr;

  assign refRise = skewRef & ~refPrev_ff;
  assign fbPer   = nomCycles(freqSel, FRAME_CYC);

  // Phase error at each reference rise, then a one-cycle slip at most;
  // the slip limit trades pull-in speed for a gentle output phase slope
  always_comb begin
    if (fbCnt_ff > (fbPer >> 1)) begin
      fbSigned = $signed({2'b00, fbCnt_ff}) - $signed({2'b00, fbPer});
    end else begin
      fbSigned = $signed({2'b00, fbCnt_ff});
    end
    phaseErr   = fbSigned + 18'(posWord * PHASE_STEP_CYC);
    step       = 2'h1;
    nxt_locked = locked_ff;
    if (curMode == MODE_MASTER && refRise) begin
      nxt_locked = (phaseErr == 18'sh0);
      if (phaseErr > 18'sh0) begin
        step = 2'h0;
      end else if (phaseErr < 18'sh0) begin
        step = 2'h2;
      end
    end else if (curMode != MODE_MASTER) begin
      nxt_locked = 1'b0;
    end
    fbSum = {1'b0, fbCnt_ff} + {15'h0000, step};
    frSum = {1'b0, frameCnt_ff} + {15'h0000, step};
    nxt_fbCnt    = (fbSum >= {1'b0, fbPer}) ? 16'(fbSum - {1'b0, fbPer}) : fbSum[15:0];
    nxt_frameCnt = (frSum >= 17'(FRAME_CYC)) ? 16'(frSum - 17'(FRAME_CYC)) : frSum[15:0];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fbCnt_ff    <= 16'h0000;
      frameCnt_ff <= 16'h0000;
      refPrev_ff  <= 1'b0;
      locked_ff   <= 1'b0;
    end else begin
      fbCnt_ff    <= nxt_fbCnt;
      frameCnt_ff <= nxt_frameCnt;
      refPrev_ff  <= skewRef;
      locked_ff   <= nxt_locked;
    end
  end

  // ----------------------------------------------------------------
  // Clock steering and timing outputs
  // ----------------------------------------------------------------
  logic nxt_stc, nxt_tick, nxt_fpo_n, nxt_sample, nxt_lmc, nxt_mfb, nxt_track;

  // Bypass hands timing to the bus clock; the loop counters keep running
  always_comb begin
    nxt_stc    = bypassOn ? busClkS : frameCnt_ff[SW_CLK_BIT];
    nxt_tick   = bypassOn ? busClkRise : (nxt_frameCnt[SW_CLK_BIT:0] == 2'h0);
    nxt_fpo_n  = bypassOn ? busFpS_n : (frameCnt_ff != 16'h0000);
    nxt_sample = busClkRise;
    nxt_lmc    = bypassOn ? 1'b0 : oscS;
    nxt_mfb    = bypassOn;
    nxt_track  = (curMode == MODE_MASTER);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      switchTimingClock     <= 1'b0;
      switchTimingTick      <= 1'b0;
      busOutputFramePulse_n <= 1'b1;
      inputSampleStrobe     <= 1'b0;
      loopMasterClock       <= 1'b0;
      multiplierFromBus     <= 1'b0;
      loopTracking          <= 1'b0;
    end else begin
      switchTimingClock     <= nxt_stc;
      switchTimingTick      <= nxt_tick;
      busOutputFramePulse_n <= nxt_fpo_n;
      inputSampleStrobe     <= nxt_sample;
      loopMasterClock       <= nxt_lmc;
      multiplierFromBus     <= nxt_mfb;
      loopTracking          <= nxt_track;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic rstDone_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstDone_ff <= 1'b0;
    end else begin
      rstDone_ff <= 1'b1;
    end
  end

  chk_reset_master_mode: assert property (!rstDone_ff |-> curMode == MODE_MASTER)
    else $error("mode after reset is not master");

  chk_bypass_write_mode: assert property (
    (accessPh && pwrite && regSel == SEL_CTRL && pwdata[CTRL_BYPASS_BIT])
      |=> curMode == MODE_BYPASS ##1 multiplierFromBus)
    else $error("bypass write did not take effect next cycle");

  chk_bypass_clk_follow: assert property (bypassOn |=> switchTimingClock == $past(busClkS))
    else $error("bypass switch clock not following bus clock");

  chk_osc_master_source: assert property (!bypassOn |=> loopMasterClock == $past(oscS))
    else $error("loop master clock not from oscillator");

  chk_free_no_slip: assert property (
    (curMode == MODE_FREERUN && frameCnt_ff < 16'(FRAME_CYC - 1))
      |=> frameCnt_ff == $past(frameCnt_ff) + 16'h0001)
    else $error("free-run counter slipped");

  chk_master_hold_late: assert property (
    (curMode == MODE_MASTER && refRise && phaseErr > 18'sh0) |=> frameCnt_ff == $past(frameCnt_ff))
    else $error("master loop did not hold on positive error");

  chk_derived_ref_sample: assert property (busClkRise |=> derived8k_ff == !$past(busFpS_n))
    else $error("derived reference not sampled on bus clock");

  chk_pol_invert_edge: assert property (
    (pinvOn && !useDerived && $stable(modeReg_ff) && $rose(extRefS)) |-> $fell(selRef))
    else $error("external reference not inverted");

  chk_sample_strobe_rise: assert property (1'b1 |=> inputSampleStrobe == $past(busClkRise))
    else $error("input sample strobe misplaced");

  chk_frame_out_start: assert property (
    (!bypassOn && frameCnt_ff == 16'h0000) |=> !busOutputFramePulse_n)
    else $error("output frame pulse missing");

  cov_master_slip: cover property (curMode == MODE_MASTER && refRise && phaseErr != 18'sh0);
  cov_bypass_run:  cover property (bypassOn && busClkRise);
  cov_freerun_on:  cover property ($rose(curMode == MODE_FREERUN));
  cov_ref_fail:    cover property ($rose(refFail));

endmodule

// [dv/tdmpl_timing_src.sv]
// Behavioural far side: bus clock, frame pulse, external reference, oscillator.
// Assumes a frame of 32 bus clocks, so 4 us, equal to FRAME_CYC of 500.
`timescale 1ns/100ps
module tdmpl_timing_src (
  // Control from the bench
  input  wire logic refOn,
  // Timing pins
  output logic      busInputClock,
  output logic      busInputFramePulse_n,
  output logic      extReference,
  output logic      oscillatorClock
);
  logic [4:0] bitCnt;
  // ----------------------------------------------------------------
  // Free-running TDM bus timing; frame pulse low one clock per frame
  // ----------------------------------------------------------------
  initial begin
    {busInputClock, oscillatorClock, extReference, bitCnt} = '0;
    busInputFramePulse_n = 1'b1;
    fork
      // Stands for the switch's own output timing fed back
      forever #62.5 busInputClock = ~busInputClock;
      forever #25 oscillatorClock = ~oscillatorClock;
      forever @(negedge busInputClock) begin
        bitCnt = bitCnt + 5'h01;
        busInputFramePulse_n = (bitCnt != 5'h00);
      end
      // Reference stands low while switched off, so a stale edge cannot pass
      forever if (refOn) begin
        extReference = 1'b1;
        #2000 extReference = 1'b0;
        #2000;
      end else #100 extReference = 1'b0;
    join
  end
endmodule

// [dv/tdmpl_mode_ctrl_tb.sv]
// Testbench of the timing-mode control: APB tasks and directed tests.
// Assumes zero-wait APB and a shortened frame of 500 cycles.
`timescale 1ns/100ps
module tdmpl_mode_ctrl_tb import tdmpl_pkg::*;;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, refOn = 1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, bic, bfp, ext, osc, stClk, stTick, fpo, iss, lmc, mfb, trk;
  int failCount = 0, numChecks = 0, cycleCnt = 0;
  logic [11:0] regOfs [4] = '{MAIN_CONTROL_OFS, PLL_MODE_OFS, PLL_STATUS_OFS, PLL_ADJUST_OFS};
  tdmpl_timing_src srcModel (.refOn(refOn), .busInputClock(bic), .busInputFramePulse_n(bfp),
    .extReference(ext), .oscillatorClock(osc));
  tdmpl_mode_ctrl #(.FRAME_CYC(500)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busInputClock(bic), .busInputFramePulse_n(bfp),
    .extReference(ext), .oscillatorClock(osc), .switchTimingClock(stClk),
    .switchTimingTick(stTick), .busOutputFramePulse_n(fpo), .inputSampleStrobe(iss),
    .loopMasterClock(lmc), .multiplierFromBus(mfb), .loopTracking(trk));
  // ----------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ----------------------------------------------------------------
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 20000) begin
      failCount++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held unchanged until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Also counts input strobes (96 bus clocks) and output frame pulses (3 frames)
  task automatic waitRef(input logic [31:0] exp);
    int nStrobe = 0;
    int nFrame = 0;
    repeat (1500) begin
      @(posedge sys_clk);
      nStrobe += int'(iss);
      nFrame += int'(!fpo);
    end
    apb(0, PLL_STATUS_OFS, '0);
    check(rd[0], exp);
    check(32'(nStrobe > 94 && nStrobe < 98), 32'h1);
    check(32'(nFrame > 1 && nFrame < 5), 32'h1);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(0, regOfs[i], '0);
      check(rd & 32'hffff_fff7, 32'h0);
    end
    check(trk, 1'b1);
    $display("test reset done");
    // Every bypass and mode bit pair, each checked four cycles after its writes
    for (int i = 0; i < 4; i++) begin
      apb(1, MAIN_CONTROL_OFS, 32'(i[1]) << CTRL_BYPASS_BIT);
      apb(1, PLL_MODE_OFS, 32'(i[0]));
      repeat (4) @(posedge sys_clk);
      apb(0, PLL_STATUS_OFS, '0);
      check(rd[2:1], i[1] ? 32'h2 : 32'(i[0]));
      check(trk, 32'(i == 0));
      check(mfb, 32'(i[1]));
    end
    apb(1, MAIN_CONTROL_OFS, '0);
    $display("test mode table done");
    apb(1, PLL_ADJUST_OFS, 32'hffff_077f);
    apb(0, PLL_ADJUST_OFS, '0);
    check(rd, 32'h0000_077f);
    apb(1, PLL_MODE_OFS, 32'h0000_001e);
    apb(0, PLL_MODE_OFS, '0);
    check(rd, 32'h0000_001e);
    apb(0, 12'h010, '0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1, PLL_ADJUST_OFS, '0);
    apb(1, PLL_MODE_OFS, '0);
    $display("test fields done");
    // External reference good, inverted, lost, then derived reference takes over
    waitRef(0);
    apb(1, PLL_MODE_OFS, 32'h1 << MODE_REF_POLARITY_INVERT_BIT);
    waitRef(0);
    refOn <= 1'b0;
    waitRef(1);
    apb(1, PLL_MODE_OFS, 32'h1 << MODE_REFSEL_BIT);
    waitRef(0);
    apb(1, PLL_MODE_OFS, '0);
    waitRef(1);
    refOn <= 1'b1;
    waitRef(0);
    $display("test reference monitor done");
    conclude();
  end
endmodule
